// ===== bench/swpm_master_tb.sv
`timescale 1ns/100ps
module swpm_master_tb;
    import swpm_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        line;
    logic        slv_low;
    logic        slv_en;
    logic [2:0]  sts;
    logic [1:0]  mode;
    logic [7:0]  lag;
    logic [22:0] seen;
    logic [7:0]  rd;
    logic [7:0]  st;
    logic        err;
    swpm_pin_s   tx_pin;
    int          n_errors;
    int          compares;
    int          k;
    int          cyc = 0;

    // pull-up on the wire; either party may pull it low
    assign line = !(tx_pin.oe && !tx_pin.o) && !slv_low;

    swpm_master dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_pin(line), .tx_pin(tx_pin));
    swpm_slave #(.SLOT(64), .MY_ADDR(3'h5)) slv (.pclk(pclk), .presetn(presetn), .line(line),
        .en(slv_en), .sts(sts), .mode(mode), .lag(lag), .drv_low(slv_low), .seen(seen));

    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            n_errors++;
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask

    task automatic rchk(input string nm, input logic [9:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        check(nm, 32'(rd), 32'(e));
    endtask

    function automatic logic [22:0] exp_frame(input logic [7:0] b);
        logic [8:0]  bits;
        logic [22:0] f;
        bits = {b, 1'b0};
        f = 23'h400000;
        for (int i = 0; i < 9; i++) begin
            f[3 + 2 * i] = !bits[i];
            f[4 + 2 * i] = bits[i];
        end
        return f;
    endfunction

    task automatic fin(input logic [7:0] b, input logic [7:0] e);
        int n;
        n = 0;
        do begin
            apb(1'b0, IDX_STAT1, 8'h00);
            n++;
        end while (rd[STAT_RDRF] !== 1'b1 && n < 2000);
        if (rd[STAT_RDRF] !== 1'b1)
            n_errors++;
        st = rd;
        check("bit error", 32'(st[STAT_NF]), 32'(mode == 2'h3));
        if (mode != 2'h3)
            check("push slots", 32'(seen), 32'(exp_frame(b)));
        rchk("pull byte", IDX_DATA, e);
    endtask

    task automatic frame(input logic [7:0] b, input logic [7:0] e);
        wr(IDX_DATA, b);
        fin(b, e);
    endtask

    task automatic brk(input int exp);
        int n;
        int w;
        wr(IDX_CTL2, 8'h0d);
        w = 0;
        while (line && w < 500) begin
            @(posedge pclk);
            w++;
        end
        n = 0;
        while (!line && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        check("break length", 32'(n), 32'(exp));
        rchk("break clear", IDX_CTL2, 8'h0c);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        slv_en = 1'b0;
        sts = 3'h0;
        mode = 2'h0;
        lag = 8'h00;
        n_errors = 0;
        compares = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("delay", IDX_DELAY, 8'h00);
        check("mapped ok", 32'(err), 32'h0);
        rchk("rate hi", IDX_RATE_HI, 8'h00);
        rchk("rate lo", IDX_RATE_LO, 8'h04);
        rchk("ctl1", IDX_CTL1, 8'h00);
        rchk("ctl2", IDX_CTL2, 8'h00);
        rchk("stat1", IDX_STAT1, 8'hc0);
        rchk("stat2", IDX_STAT2, 8'h00);
        apb(1'b0, 10'h060, 8'h00);
        check("unmapped", 32'(err), 32'h1);
        wr(IDX_DELAY, 8'hff);
        rchk("delay all", IDX_DELAY, 8'hfb);
        wr(IDX_DELAY, 8'h01);
        rchk("delay lock", IDX_DELAY, 8'hf1);
        wr(IDX_CTL2, 8'h0c);
        wr(IDX_DATA, 8'ha5);
        check("port off", 32'(tx_pin.oe), 32'h0);
        wr(IDX_CTL1, 8'h20);
        slv_en <= 1'b1;
        // the pin register follows a control write one cycle later
        @(posedge pclk);
        check("idle pin", 32'(tx_pin), 32'h3);
        for (int s = 0; s < 8; s++) begin
            sts <= s[2:0];
            frame({3'h5, 2'h1, s[2:0]}, (s == 0 || s == 7) ? 8'hff : {4'h5, s[2:0], 1'b1});
        end
        sts <= 3'h3;
        mode <= 2'h2;
        frame(8'ha3, 8'hff);
        mode <= 2'h0;
        frame(8'h23, 8'hff);
        mode <= 2'h3;
        frame(8'ha3, 8'hff);
        mode <= 2'h0;
        // late pull bits: a long delay catches them, the shortest reads the previous slot
        lag <= 8'h08;
        sts <= 3'h4;
        wr(IDX_DELAY, 8'h03);
        frame(8'ha0, 8'h59);
        wr(IDX_DELAY, 8'h00);
        frame(8'ha0, 8'h53);
        lag <= 8'h00;
        wr(IDX_DELAY, 8'h01);
        wr(IDX_CTL1, 8'h60);
        frame(8'ha3, 8'h59);
        check("drain idle", 32'(tx_pin), 32'h0);
        slv_en <= 1'b0;
        wr(IDX_CTL1, 8'h21);
        @(posedge pclk);
        check("invert idle", 32'(tx_pin), 32'h1);
        wr(IDX_CTL1, 8'h20);
        slv_en <= 1'b1;
        brk(1280);
        wr(IDX_RATE_LO, 8'h02);
        brk(640);
        wr(IDX_RATE_HI, 8'h01);
        brk(640);
        rchk("rate lo", IDX_RATE_LO, 8'h02);
        wr(IDX_RATE_HI, 8'h00);
        wr(IDX_RATE_LO, 8'h00);
        wr(IDX_DATA, 8'ha3);
        k = 0;
        repeat (400) begin
            @(posedge pclk);
            if (!line)
                k++;
        end
        check("stopped rate", 32'(k), 32'h0);
        wr(IDX_RATE_LO, 8'h04);
        fin(8'ha3, 8'h59);
        end_sim();
    end
endmodule

// ===== bench/swpm_slave.sv
`timescale 1ns/100ps
module swpm_slave #(
    parameter int         SLOT    = 64,
    parameter logic [2:0] MY_ADDR = 3'h5
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        line,
    input  wire logic        en,
    input  wire logic [2:0]  sts,
    input  wire logic [1:0]  mode,
    input  wire logic [7:0]  lag,
    output logic             drv_low,
    output logic [22:0]      seen
);
    logic [22:0] early;
    logic        act;
    logic        ok;
    int          cnt;
    int          lowc;
    int          sl;
    int          ph;

    // mode 2 withholds the end of frame, mode 3 jams the first sync slot
    always_comb begin
        ok = (early == seen) && (seen[2:0] == 3'h0) && seen[3];
        for (int i = 0; i < 9; i++) begin
            ok = ok && (seen[3 + 2 * i] != seen[4 + 2 * i]);
        end
    end

    function automatic logic reply(input int s);
        logic go;
        go = ok && (~{seen[19], seen[17], seen[15]} == MY_ADDR);
        if (!go) begin
            return 1'b0;
        end
        if (s < 26) begin
            return !sts[s - 23];
        end
        return (mode != 2'h2) && (s % 2 == 0);
    endfunction

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act <= 1'b0;
            cnt <= 0;
            lowc <= 0;
            drv_low <= 1'b0;
            early <= '0;
            seen <= '0;
        end else begin
            lowc <= line ? 0 : lowc + 1;
            cnt <= cnt + 1;
            sl = cnt / SLOT;
            ph = cnt % SLOT;
            if (!act) begin
                drv_low <= 1'b0;
                cnt <= 1;
                act <= en && !line && lowc == 0;
            end else if (lowc >= 8 * SLOT || sl >= 30) begin
                // a long dominant level disables our outputs until the wire recovers
                act <= 1'b0;
                drv_low <= 1'b0;
            end else begin
                if (sl < 23 && ph == SLOT / 4) begin
                    early[sl] <= line;
                end
                if (sl < 23 && ph == 3 * SLOT / 4) begin
                    seen[sl] <= line;
                end
                if (mode == 2'h3 && ph == 0 && sl < 5) begin
                    drv_low <= (sl == 3);
                end
                if (sl >= 23 && ph == lag) begin
                    drv_low <= reply(sl);
                end
            end
        end
    end
endmodule

// ===== design/swpm_master.sv
// Behaviour
// - right after the last address bit the master sends the pull sync as biphase one
// - pull data is taken NRZ, one slot per bit, into the data low byte
// - push bits take two slots; one is low then high, zero high then low
// - valid only when code is not 111 or 000 and a square wave follows
// - code 111 with the end of frame stuck high means a bus error
// - during the push the rx pin is compared with the sent level; mismatch sets noise flag
// - bus clock is the input clock over 16 times twice the 13-bit divisor
// - the rate generator stops at divisor zero or with both enables clear
// - a divisor update lands only when the low byte is written last
// - a time slot is half a push bit, 25 us at 20 kHz
// - pull sampling starts one to four sixteenths of a slot after slot start
// - delay register always readable; top nibble writable once, bits 3,1,0 always
// - bit 2 of the delay register reads zero
// - the bus enable bit turns the shared port into the single-wire master
// - the wired-or bit makes the tx pin open drain
// - the invert bit drives inverted data on the tx pin
// - push is three low slots, sync zero, five data bits, three address bits
// - data bits come from byte bits 4..0, address from bits 7..5
// - valid byte is 0101 sss1; all ones marks a bus error
// - send break holds the line low for 20 slots
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module swpm_master (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               rx_pin,
    output swpm_pkg::swpm_pin_s     tx_pin
);
    import swpm_pkg::*;

    swpm_regs_s r;
    swpm_regs_s n;

    logic       hit;
    logic [9:0] idx;
    logic       do_wr;
    logic       do_rd;
    logic       rate_on;
    logic       tick;
    logic       slot_end;
    logic       samp;
    logic       valid;
    logic       level;
    logic [7:0] rd_byte;

    // level of push-field slot s: slot pair 0 is the sync zero, then d lsb first
    function automatic logic push_level(input logic [7:0] d, input logic [4:0] s);
        logic [3:0] k;
        logic       b;
        k = s[4:1] - 4'h1;
        b = (s[4:1] == 4'h0) ? 1'b0 : d[k[2:0]];
        return s[0] ? b : ~b;
    endfunction

    function automatic logic at_idx(input logic [11:0] a, input logic [9:0] i);
        return (a[11:2] == i) && (a[1:0] == 2'b00);
    endfunction

    always_comb begin
        n       = r;
        idx     = paddr[11:2];
        hit     = at_idx(paddr, IDX_DELAY) || at_idx(paddr, IDX_RATE_HI)
                || at_idx(paddr, IDX_RATE_LO) || at_idx(paddr, IDX_CTL1)
                || at_idx(paddr, IDX_CTL2) || at_idx(paddr, IDX_STAT1)
                || at_idx(paddr, IDX_STAT2) || at_idx(paddr, IDX_DATA);
        do_wr   = psel && penable && r.pready && pwrite && hit;
        do_rd   = psel && penable && r.pready && !pwrite && hit;
        rd_byte = 8'h00;
        valid   = 1'b0;
        level   = 1'b1;

        // read mux; prepared during the first access cycle, shown with pready
        case (idx)
            IDX_DELAY:   rd_byte = r.delay & ~(8'h01 << DELAY_ZERO);
            IDX_RATE_HI: rd_byte = r.rate_hi;
            IDX_RATE_LO: rd_byte = r.rate[7:0];
            IDX_CTL1:    rd_byte = r.ctl1;
            IDX_CTL2:    rd_byte = r.ctl2;
            IDX_STAT1: begin
                rd_byte[STAT_TDRE] = !r.tx_full;
                rd_byte[STAT_TC]   = r.tc;
                rd_byte[STAT_RDRF] = r.rdrf;
                rd_byte[STAT_NF]   = r.nf;
            end
            IDX_STAT2:   rd_byte = {7'h00, (r.st == S_PULL) || (r.st == S_EOF)};
            IDX_DATA:    rd_byte = r.rxd;
            default:     rd_byte = 8'h00;
        endcase
        n.pready  = psel && penable && !r.pready;
        n.pslverr = psel && penable && !r.pready && !hit;
        n.prdata  = (psel && penable && !r.pready) ? {24'h000000, rd_byte} : 32'h00000000;

        // software side effects; hardware sets below come later and win
        if (do_wr) begin
            case (idx)
                IDX_DELAY: begin
                    n.delay = (r.delay & ~DELAY_ANY_MASK) | (pwdata[7:0] & DELAY_ANY_MASK);
                    if (!r.dly_locked) begin
                        n.delay = (n.delay & ~DELAY_ONCE_MASK) | (pwdata[7:0] & DELAY_ONCE_MASK);
                        n.dly_locked = 1'b1;
                    end
                end
                IDX_RATE_HI: n.rate_hi = pwdata[7:0];
                IDX_RATE_LO: n.rate = {r.rate_hi[4:0], pwdata[7:0]};
                IDX_CTL1:    n.ctl1 = pwdata[7:0] & 8'h61;
                IDX_CTL2:    n.ctl2 = pwdata[7:0] & 8'h0d;
                IDX_DATA: begin
                    if (r.ctl1[CTL1_EN]) begin
                        n.txd     = pwdata[7:0];
                        n.tx_full = 1'b1;
                        n.tc      = 1'b0;
                    end
                end
                default: n.rate_hi = r.rate_hi;
            endcase
        end
        if (do_rd && (idx == IDX_STAT1)) begin
            n.snap = {r.rdrf, r.nf};
        end
        if (do_rd && (idx == IDX_DATA)) begin
            // only flags seen by the status read are cleared
            n.rdrf = r.rdrf && !r.snap[1];
            n.nf   = r.nf && !r.snap[0];
            n.snap = 2'b00;
        end

        // rate generator: one tick per sixteenth of a slot
        rate_on = (r.rate != 13'h0000) && (r.ctl2[CTL2_RE] || r.ctl2[CTL2_TE]);
        tick    = 1'b0;
        if (!rate_on) begin
            n.rcnt = 13'h0000;
        end else if (r.rcnt >= r.rate - 13'h0001) begin
            n.rcnt = 13'h0000;
            tick   = 1'b1;
        end else begin
            n.rcnt = r.rcnt + 13'h0001;
        end
        if (tick) begin
            n.sub = r.sub + 4'h1;
        end
        slot_end = tick && (r.sub == SLOT_LAST);
        samp     = tick && (r.sub == {2'b00, r.delay[1:0]});

        // bit monitor on the wire while pushing
        if (tick && (r.sub == CHECK_SUB) && (r.st == S_PUSH) && (rx_pin != r.line)) begin
            n.nf = 1'b1;
        end

        case (r.st)
            S_IDLE: begin
                n.line = 1'b1;
                if (slot_end && r.ctl1[CTL1_EN]) begin
                    n.slot = 5'h00;
                    if (r.ctl2[CTL2_BRK]) begin
                        n.st   = S_BREAK;
                        n.line = 1'b0;
                    end else if (r.tx_full && r.ctl2[CTL2_TE]) begin
                        n.st      = S_START;
                        n.line    = 1'b0;
                        n.psh     = r.txd;
                        // a data write landing in this very cycle stays queued for the next frame
                        n.tx_full = do_wr && (idx == IDX_DATA);
                    end
                end
            end
            S_START: begin
                if (slot_end) begin
                    n.slot = r.slot + 5'h01;
                    if (r.slot == START_LAST) begin
                        n.st   = S_PUSH;
                        n.slot = 5'h00;
                        n.line = push_level(r.psh, 5'h00);
                    end
                end
            end
            S_PUSH: begin
                if (slot_end) begin
                    n.slot = r.slot + 5'h01;
                    n.line = push_level(r.psh, r.slot + 5'h01);
                    if (r.slot == PUSH_LAST) begin
                        n.st   = S_PSYNC;
                        n.slot = 5'h00;
                        n.line = 1'b0;
                    end
                end
            end
            S_PSYNC: begin
                if (slot_end) begin
                    n.slot = r.slot + 5'h01;
                    n.line = 1'b1;
                    if (r.slot == PSYNC_LAST) begin
                        n.st    = S_PULL;
                        n.slot  = 5'h00;
                        n.shift = 3'b000;
                    end
                end
            end
            S_PULL: begin
                n.line = 1'b1;
                if (samp) begin
                    n.shift = {rx_pin, r.shift[2:1]};
                end
                if (slot_end) begin
                    n.slot = r.slot + 5'h01;
                    if (r.slot == PULL_LAST) begin
                        n.st   = S_EOF;
                        n.slot = 5'h00;
                        n.saw0 = 1'b0;
                        n.saw1 = 1'b0;
                    end
                end
            end
            S_EOF: begin
                n.line = 1'b1;
                if (samp) begin
                    n.saw0 = r.saw0 || !rx_pin;
                    n.saw1 = r.saw1 || rx_pin;
                end
                if (slot_end) begin
                    n.slot = r.slot + 5'h01;
                    if (r.slot == EOF_LAST) begin
                        // the last sample lands earlier in this slot, so r.saw* are complete
                        valid = (r.shift != 3'b111) && (r.shift != 3'b000)
                              && r.saw0 && r.saw1;
                        if (r.ctl2[CTL2_RE]) begin
                            n.rxd  = valid ? {VALID_HEAD, r.shift, 1'b1} : BUS_ERR;
                            n.rdrf = 1'b1;
                        end
                        n.tc   = 1'b1;
                        n.st   = S_IDLE;
                        n.slot = 5'h00;
                    end
                end
            end
            S_BREAK: begin
                n.line = 1'b0;
                if (slot_end) begin
                    n.slot = r.slot + 5'h01;
                    if (r.slot == BREAK_LAST) begin
                        n.st   = S_IDLE;
                        n.slot = 5'h00;
                        n.line = 1'b1;
                        n.ctl2[CTL2_BRK] = 1'b0;
                    end
                end
            end
            default: begin
                n.st   = S_IDLE;
                n.line = 1'b1;
            end
        endcase

        // leaving bus mode abandons any frame and releases the wire
        if (!r.ctl1[CTL1_EN]) begin
            n.st   = S_IDLE;
            n.line = 1'b1;
        end

        level = n.line ^ r.ctl1[CTL1_INV];
        if (!r.ctl1[CTL1_EN] || !r.ctl2[CTL2_TE]) begin
            n.tx = '{o: 1'b1, oe: 1'b0};
        end else if (r.ctl1[CTL1_OD]) begin
            n.tx = '{o: 1'b0, oe: !level};
        end else begin
            n.tx = '{o: level, oe: 1'b1};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r            <= '0;
            r.st         <= S_IDLE;
            r.delay      <= DELAY_RST;
            r.rate_hi    <= RATE_HI_RST;
            r.rate       <= RATE_RST;
            r.ctl1       <= CTL_RST;
            r.ctl2       <= CTL_RST;
            r.tc         <= 1'b1;
            r.line       <= 1'b1;
            r.tx         <= '{o: 1'b1, oe: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign prdata  = r.prdata;
    assign pready  = r.pready;
    assign pslverr = r.pslverr;
    assign tx_pin  = r.tx;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_access_wait;
        psel && penable && !pready;
    endsequence
    sequence s_start_entry;
        (r.st == S_IDLE) ##1 (r.st == S_START);
    endsequence

    a_apb_answer: assert property (s_access_wait |=> pready)
        else $error("apb access not answered in one cycle");
    a_start_low: assert property (s_start_entry |-> !r.line && (r.slot == 5'h00))
        else $error("start field not low");
    a_push_code: assert property ((r.st == S_PUSH) |->
            (r.line == push_level(r.psh, r.slot)))
        else $error("push slot level wrong");
    a_psync_code: assert property ((r.st == S_PSYNC) |-> (r.line == r.slot[0]))
        else $error("pull sync not a biphase one");
    a_line_idle: assert property (((r.st == S_IDLE) || (r.st == S_PULL) || (r.st == S_EOF))
            |-> r.line)
        else $error("line not recessive");
    a_break_low: assert property ((r.st == S_BREAK) |-> !r.line)
        else $error("break not low");
    a_bit_error: assert property ((tick && (r.sub == CHECK_SUB) && (r.st == S_PUSH)
            && (rx_pin != r.line)) |=> r.nf)
        else $error("bit error not flagged");
    a_rate_stop: assert property ((r.rate == 13'h0000) |=> (r.rcnt == 13'h0000)
            && $stable(r.sub))
        else $error("rate generator ran while stopped");
    a_pull_byte: assert property (($rose(r.rdrf) && (r.rxd != BUS_ERR)) |->
            (r.rxd[7:4] == VALID_HEAD) && r.rxd[0]
            && (r.rxd[3:1] != 3'b111) && (r.rxd[3:1] != 3'b000))
        else $error("stored pull byte malformed");
    a_delay_bit2: assert property ((pready && !pwrite && (paddr[11:2] == IDX_DELAY))
            |-> !prdata[DELAY_ZERO])
        else $error("delay bit 2 read as one");
    a_tx_polar: assert property ((!r.ctl1[CTL1_OD] && r.tx.oe && $stable(r.ctl1))
            |-> (r.tx.o == (r.line ^ r.ctl1[CTL1_INV])))
        else $error("tx polarity wrong");

endmodule

// ===== design/swpm_pkg.sv
package swpm_pkg;

    // register indices; the byte address is four times the index
    localparam logic [9:0] IDX_DELAY   = 10'h037;
    localparam logic [9:0] IDX_RATE_HI = 10'h050;
    localparam logic [9:0] IDX_RATE_LO = 10'h051;
    localparam logic [9:0] IDX_CTL1    = 10'h052;
    localparam logic [9:0] IDX_CTL2    = 10'h053;
    localparam logic [9:0] IDX_STAT1   = 10'h054;
    localparam logic [9:0] IDX_STAT2   = 10'h055;
    localparam logic [9:0] IDX_DATA    = 10'h057;

    localparam logic [7:0]  DELAY_RST   = 8'h00;
    localparam logic [7:0]  RATE_HI_RST = 8'h00;
    localparam logic [12:0] RATE_RST    = 13'h0004;
    localparam logic [7:0]  CTL_RST     = 8'h00;

    // field positions
    localparam int CTL1_OD    = 6;
    localparam int CTL1_EN    = 5;
    localparam int CTL1_INV   = 0;
    localparam int CTL2_TE    = 3;
    localparam int CTL2_RE    = 2;
    localparam int CTL2_BRK   = 0;
    localparam int STAT_TDRE  = 7;
    localparam int STAT_TC    = 6;
    localparam int STAT_RDRF  = 5;
    localparam int STAT_NF    = 2;
    localparam int DELAY_ZERO = 2;
    localparam logic [7:0] DELAY_ONCE_MASK = 8'hf0;
    localparam logic [7:0] DELAY_ANY_MASK  = 8'h0b;

    // frame shape, counted in time slots and sixteenth-slot units
    localparam logic [3:0] SLOT_LAST   = 4'hf;
    localparam logic [3:0] CHECK_SUB   = 4'h8;
    localparam logic [4:0] START_LAST  = 5'h02;
    localparam logic [4:0] PUSH_LAST   = 5'h11;
    localparam logic [4:0] PSYNC_LAST  = 5'h01;
    localparam logic [4:0] PULL_LAST   = 5'h02;
    localparam logic [4:0] EOF_LAST    = 5'h03;
    localparam logic [4:0] BREAK_LAST  = 5'h13;
    localparam logic [3:0] VALID_HEAD  = 4'h5;
    localparam logic [7:0] BUS_ERR     = 8'hff;

    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_START = 7'h02,
        S_PUSH  = 7'h04,
        S_PSYNC = 7'h08,
        S_PULL  = 7'h10,
        S_EOF   = 7'h20,
        S_BREAK = 7'h40
    } swpm_state_e;

    typedef struct packed {
        logic o;
        logic oe;
    } swpm_pin_s;

    typedef struct packed {
        swpm_state_e st;
        logic [7:0]  delay;
        logic        dly_locked;
        logic [7:0]  rate_hi;
        logic [12:0] rate;
        logic [7:0]  ctl1;
        logic [7:0]  ctl2;
        logic [7:0]  txd;
        logic        tx_full;
        logic [7:0]  psh;
        logic        tc;
        logic        rdrf;
        logic        nf;
        logic [1:0]  snap;
        logic [7:0]  rxd;
        logic [12:0] rcnt;
        logic [3:0]  sub;
        logic [4:0]  slot;
        logic [2:0]  shift;
        logic        saw0;
        logic        saw1;
        logic        line;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        swpm_pin_s   tx;
    } swpm_regs_s;

endpackage
